// [sst_timing.sv]
/*
 timing core of a six-channel supply sequencer: enable delays, restart delays, reset time-out,
 termination timer, converter scan and trim loop scheduling, with an ahb-lite register slave.
 assumes supply_monitor_in_i is high while a channel is above its first undervoltage limit.
*/
// Function
// [RQ1] each channel's enable goes active its programmable turn-on delay after its position starts.
// [RQ2] a channel whose monitor drops waits its turn-off delay before its enable goes inactive.
// [RQ3] the reset time-out delay is selectable among 0.64, 25, 100 and 200 ms.
// [RQ4] the sequence termination timer is off or 100, 200 or 400 ms and forces shutdown on expiry.
// [RQ5] after a fault shutdown the enables restart after 2.4 s.
// [RQ6] after a command shutdown the enables restart after 12.5 ms.
// [RQ7] the 11 converter channels are scanned in turn, 182 us each, about 2 ms per scan.
// [RQ8] the trim loop visits channels a to f in turn, 283 us each, about 1.7 ms per round.
// [RQ9] the host allows 10 ms after a configuration write and 5 ms after a memory write.
// [RQ10] a sequence starts on the rising request and the requester holds it high until done.
// [RQ11] the next position starts only when every monitor of the current position is good.
// [RQ12] after forced shutdown the block latches off with zero retries, else restarts after 2.4 s.
// [RQ13] each regulated channel gets one 5 us correction pulse per 1.7 ms round.
// [RQ14] all delays and periods count one shared 1 us timebase.
`timescale 1ns/1ps
`include "sst_defines.svh"
module sst_timing import sst_pkg::*; #(
	parameter logic [15:0] TICK_CYC = 16'(`SST_TICK_CYC),
	parameter logic [23:0] FAULT_RESTART_DELAY_US  = `SST_FAULT_RESTART_DELAY_US,
	parameter logic [23:0] COMMAND_RESTART_DELAY_US  = `SST_COMMAND_RESTART_DELAY_US
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        hsel_i,
	input  wire logic [7:0]  haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        sequence_request_in_i,
	input  wire logic [5:0]  supply_monitor_in_i,
	input  wire logic [5:0]  trim_above_i,
	output logic      [5:0]  supply_enable_out_o,
	output logic             supply_good_o,
	output logic      [3:0]  adc_channel_o,
	output logic             adc_start_o,
	output logic      [5:0]  trim_pulse_o,
	output logic      [5:0]  trim_source_o,
	output logic             irq_o
);
	sst_regs_t q;
	sst_regs_t d;

	// kind 0 on/off delay, 1 reset time-out, 2 termination timer (0 means off)
	function automatic logic [23:0] sel_us(input logic [1:0] kind, input logic [1:0] sel);
		logic [23:0] r;
		r = 24'h0;
		case (kind)
			2'd0: r = (sel == 2'd0) ? `SST_T_0P64MS_US : (sel == 2'd1) ? `SST_T_12P5MS_US :
				(sel == 2'd2) ? `SST_T_25MS_US : `SST_T_50MS_US;
			2'd1: r = (sel == 2'd0) ? `SST_T_0P64MS_US : (sel == 2'd1) ? `SST_T_25MS_US :
				(sel == 2'd2) ? `SST_T_100MS_US : `SST_T_200MS_US;
			default: r = (sel == 2'd0) ? 24'h0 : (sel == 2'd1) ? `SST_T_100MS_US :
				(sel == 2'd2) ? `SST_T_200MS_US : `SST_T_400MS_US;
		endcase
		return r;
	endfunction

	function automatic logic [5:0] in_pos(input sst_chan_cfg_t [5:0] c, input logic [2:0] p);
		logic [5:0] m;
		m = 6'h0;
		for (int i = 0; i < 6; i++) begin
			m[i] = (c[i].pos == p);
		end
		return m;
	endfunction

	logic        acc;
	logic        cmd_off;
	logic        unlatch;
	logic        fault;
	logic [3:0]  evt;
	logic [3:0]  rd_clr;
	logic [5:0]  pmask;

	always_comb begin
		d = q;
		acc = hsel_i & htrans_i[1] & hready_i;
		cmd_off = 1'b0;
		unlatch = 1'b0;
		fault = 1'b0;
		evt = 4'h0;
		rd_clr = 4'h0;
		pmask = in_pos(q.cfg, q.pos);
		d.hready = 1'b1;
		d.tick = 1'b0;
		d.adc_start = 1'b0;
		d.trim_pulse = 6'h0;
		// second stage only feeds logic; first stage is read by nothing else
		d.mon_s1 = supply_monitor_in_i;
		d.mon_s2 = q.mon_s1;
		d.abv_s1 = trim_above_i;
		d.abv_s2 = q.abv_s1;
		d.req_s1 = sequence_request_in_i;
		d.req_s2 = q.req_s1;
		d.req_d = q.req_s2;

		if (q.tick_cnt == TICK_CYC - 16'h1) begin // [RQ14]
			d.tick_cnt = 16'h0;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 16'h1;
		end

		// data phase of a write lands one cycle after its address phase
		if (q.wr_pend) begin
			if (q.wr_addr == `SST_REG_CTRL) begin
				cmd_off = hwdata_i[`SST_CTRL_CMD_OFF];
				unlatch = hwdata_i[`SST_CTRL_UNLATCH];
				d.reset_timeout_delay_sel = hwdata_i[`SST_CTRL_RESET_TIMEOUT_DELAY_LO +: 2];
				d.stt_sel = hwdata_i[`SST_CTRL_STT_LO +: 2];
				d.retries = hwdata_i[`SST_CTRL_RETRY_LO +: 3];
			end else if (q.wr_addr == `SST_REG_MASK) begin
				d.irq_mask = hwdata_i[3:0];
			end
			for (int i = 0; i < 6; i++) begin
				if (q.wr_addr == `SST_REG_CH0 + 8'(4 * i)) begin
					d.cfg[i] = hwdata_i[8:0];
				end
			end
		end
		d.wr_pend = acc & hwrite_i;
		d.wr_addr = haddr_i;
		if (acc && !hwrite_i) begin
			case (haddr_i)
				`SST_REG_CTRL: d.hrdata = {23'h0, q.retries, q.stt_sel, q.reset_timeout_delay_sel, 2'h0};
				`SST_REG_STATUS: d.hrdata = {11'h0, q.good, 1'b0, q.st, 1'b0, q.pos, q.mon_s2, q.en};
				`SST_REG_IRQ: begin
					d.hrdata = {28'h0, q.irq_st};
					rd_clr = 4'hf;
				end
				`SST_REG_MASK: d.hrdata = {28'h0, q.irq_mask};
				default: begin
					d.hrdata = 32'h0;
					for (int i = 0; i < 6; i++) begin
						if (haddr_i == `SST_REG_CH0 + 8'(4 * i)) begin
							d.hrdata = {23'h0, q.cfg[i]};
						end
					end
				end
			endcase
		end

		if (q.tick && (q.st == SST_ON_DLY || q.st == SST_WAIT_UV || q.st == SST_RESTART ||
			q.st == SST_RESET_TO)) begin
			d.seq_cnt = q.seq_cnt + 24'h1; // [RQ14]
		end
		if (q.tick && (q.st == SST_ON_DLY || q.st == SST_WAIT_UV)) begin
			d.stt_cnt = q.stt_cnt + 24'h1;
		end

		case (q.st)
			SST_IDLE: begin
				if (q.req_s2 && !q.req_d) begin // [RQ10]
					d.st = SST_ON_DLY;
					d.pos = 3'd1;
					d.seq_cnt = 24'h0;
					d.stt_cnt = 24'h0;
				end
			end
			SST_RESTART: begin
				if (q.seq_cnt >= (q.fault_rst ? FAULT_RESTART_DELAY_US : COMMAND_RESTART_DELAY_US)) begin // [RQ5] [RQ6] [RQ12]
					d.st = SST_ON_DLY;
					d.pos = 3'd1;
					d.seq_cnt = 24'h0;
					d.stt_cnt = 24'h0;
				end
			end
			SST_ON_DLY: begin
				for (int i = 0; i < 6; i++) begin
					if (pmask[i] && q.seq_cnt >= sel_us(2'd0, q.cfg[i].on_sel)) begin
						d.en[i] = 1'b1; // [RQ1]
					end
				end
				if ((pmask & ~d.en) == 6'h0) begin
					d.st = SST_WAIT_UV;
				end
			end
			SST_WAIT_UV: begin
				if ((pmask & ~q.mon_s2) == 6'h0) begin // [RQ11]
					d.seq_cnt = 24'h0;
					if (q.pos == `SST_POS_LAST) begin
						d.st = SST_RESET_TO;
						evt[`SST_EV_SEQ_DONE] = 1'b1;
					end else begin
						d.st = SST_ON_DLY;
						d.pos = q.pos + 3'd1;
					end
				end
			end
			SST_RESET_TO: begin
				if (q.seq_cnt >= sel_us(2'd1, q.reset_timeout_delay_sel)) begin // [RQ3]
					d.st = SST_RUN;
					d.good = 1'b1;
					evt[`SST_EV_GOOD] = 1'b1;
				end
			end
			SST_RUN: begin
				// sequence-off: the outside party dropped its request
				if (!q.req_s2) begin
					d.st = SST_IDLE;
					d.en = 6'h0;
					d.good = 1'b0;
				end
			end
			SST_LATCHED: begin
				if (unlatch) begin
					d.st = SST_IDLE;
				end
			end
			default: d.st = SST_IDLE;
		endcase

		// monitor loss only counts once the supplies are up; dips during ramp are expected
		for (int i = 0; i < 6; i++) begin
			if (!(q.st == SST_RUN || q.st == SST_RESET_TO) || !q.en[i] || q.mon_s2[i]) begin
				d.off_cnt[i] = 16'h0;
			end else if ({8'h0, q.off_cnt[i]} >= sel_us(2'd0, q.cfg[i].off_sel)) begin
				d.en[i] = 1'b0; // [RQ2]
				fault = 1'b1;
			end else if (q.tick) begin
				d.off_cnt[i] = q.off_cnt[i] + 16'h1;
			end
		end
		if ((q.st == SST_ON_DLY || q.st == SST_WAIT_UV) && q.stt_sel != 2'd0 &&
			q.stt_cnt >= sel_us(2'd2, q.stt_sel)) begin
			fault = 1'b1; // [RQ4]
			evt[`SST_EV_STT] = 1'b1;
		end
		if (cmd_off && q.st != SST_IDLE && q.st != SST_LATCHED) begin
			d.st = SST_RESTART; // [RQ6]
			d.fault_rst = 1'b0;
			d.en = 6'h0;
			d.good = 1'b0;
			d.seq_cnt = 24'h0;
		end else if (fault) begin
			d.st = (q.retries == 3'd0) ? SST_LATCHED : SST_RESTART; // [RQ12]
			d.fault_rst = 1'b1;
			d.en = 6'h0;
			d.good = 1'b0;
			d.seq_cnt = 24'h0;
			evt[`SST_EV_FAULT] = 1'b1;
		end

		if (q.tick) begin
			if (q.adc_cnt == `SST_ADC_SLOT_US - 9'd1) begin // [RQ7]
				d.adc_cnt = 9'h0;
				d.adc_ch = (q.adc_ch == `SST_ADC_CHANS - 4'd1) ? 4'h0 : q.adc_ch + 4'h1;
				d.adc_start = 1'b1;
			end else begin
				d.adc_cnt = q.adc_cnt + 9'h1;
			end
			if (q.loop_cnt == `SST_LOOP_SLOT_US - 9'd1) begin // [RQ8]
				d.loop_cnt = 9'h0;
				d.loop_ch = (q.loop_ch == `SST_LOOP_CHANS - 3'd1) ? 3'h0 : q.loop_ch + 3'h1;
			end else begin
				d.loop_cnt = q.loop_cnt + 9'h1;
			end
		end
		// one pulse per slot; the direction follows the comparator at slot start
		if (q.st == SST_RUN && q.cfg[q.loop_ch].reg_en && q.loop_cnt < `SST_TRIM_PULSE_US) begin
			d.trim_pulse[q.loop_ch] = 1'b1; // [RQ13]
			if (!q.trim_pulse[q.loop_ch]) begin
				d.trim_src[q.loop_ch] = ~q.abv_s2[q.loop_ch];
			end
		end

		for (int i = 0; i < 6; i++) begin
			d.en_pin[i] = d.en[i] ^ d.cfg[i].pol;
		end
		// a new event wins over a read clear in the same cycle
		d.irq_st = (q.irq_st & ~rd_clr) | evt;
		d.irq = |(d.irq_st & d.irq_mask);
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.hready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign hrdata_o = q.hrdata;
	assign hreadyout_o = q.hready;
	assign hresp_o = 1'b0;
	assign supply_enable_out_o = q.en_pin;
	assign supply_good_o = q.good;
	assign adc_channel_o = q.adc_ch;
	assign adc_start_o = q.adc_start;
	assign trim_pulse_o = q.trim_pulse;
	assign trim_source_o = q.trim_src;
	assign irq_o = q.irq;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	property p_on_dly;
		$rose(q.en[0]) |-> q.seq_cnt >= sel_us(2'd0, q.cfg[0].on_sel);
	endproperty
	a_on_dly: assert property (p_on_dly) else $error("enable rose before its turn-on delay"); // [RQ1]

	property p_off_dly;
		$fell(q.en[0]) && $past(q.st) == SST_RUN && $past(q.req_s2) && !$past(q.wr_pend) &&
			($past(q.en[5:1]) & ~$past(q.mon_s2[5:1])) == 5'h0 |->
			{8'h0, $past(q.off_cnt[0])} >= sel_us(2'd0, $past(q.cfg[0].off_sel));
	endproperty
	a_off_dly: assert property (p_off_dly) else $error("enable fell before its turn-off delay"); // [RQ2]

	property p_reset_timeout_delay;
		q.st == SST_RESET_TO ##1 q.st == SST_RUN |-> $past(q.seq_cnt) >= sel_us(2'd1, q.reset_timeout_delay_sel);
	endproperty
	a_reset_timeout_delay: assert property (p_reset_timeout_delay) else $error("reset time-out ended early"); // [RQ3]

	property p_stt;
		$rose(q.irq_st[`SST_EV_STT]) |-> $past(q.stt_sel) != 2'd0 && q.en == 6'h0;
	endproperty
	a_stt: assert property (p_stt) else $error("termination fired while off or kept enables"); // [RQ4]

	property p_restart;
		q.st == SST_RESTART ##1 q.st == SST_ON_DLY |->
			$past(q.seq_cnt) >= ($past(q.fault_rst) ? FAULT_RESTART_DELAY_US : COMMAND_RESTART_DELAY_US);
	endproperty
	a_restart: assert property (p_restart) else $error("restart delay cut short"); // [RQ5] [RQ6]

	property p_adc;
		q.adc_start |-> q.adc_cnt == 9'h0 && q.adc_ch < `SST_ADC_CHANS ##1 !q.adc_start;
	endproperty
	a_adc: assert property (p_adc) else $error("converter slot out of step"); // [RQ7]

	property p_loop;
		$changed(q.loop_ch) |-> $past(q.loop_cnt) == `SST_LOOP_SLOT_US - 9'd1 && q.loop_ch < `SST_LOOP_CHANS;
	endproperty
	a_loop: assert property (p_loop) else $error("trim loop slot length wrong"); // [RQ8]

	property p_adv;
		$past(q.st) == SST_WAIT_UV && $changed(q.pos) |-> ($past(pmask) & ~$past(q.mon_s2)) == 6'h0;
	endproperty
	a_adv: assert property (p_adv) else $error("position advanced with a low monitor"); // [RQ11]

	property p_latch;
		$rose(q.irq_st[`SST_EV_FAULT]) && $past(q.retries) == 3'd0 && !$past(cmd_off) |->
			q.st == SST_LATCHED;
	endproperty
	a_latch: assert property (p_latch) else $error("zero retries did not latch off"); // [RQ12]

	property p_trim;
		|q.trim_pulse |-> $past(q.loop_cnt) < `SST_TRIM_PULSE_US && $past(q.st) == SST_RUN;
	endproperty
	a_trim: assert property (p_trim) else $error("trim pulse outside its window"); // [RQ13]

	c_done: cover property (q.st == SST_RESET_TO ##1 q.st == SST_RUN);
	c_fault: cover property (q.st == SST_RUN ##1 q.st == SST_RESTART);
	c_latch: cover property ($rose(q.st == SST_LATCHED));
	c_trim: cover property ($rose(|q.trim_pulse));
endmodule // sst_timing

// [sst_defines.svh]
/*
 timing counts, register offsets and field positions of the supply sequence timing core.
 assumes a 20 MHz system clock and a 1 us internal timebase derived from it.
*/
`ifndef SST_DEFINES_SVH
`define SST_DEFINES_SVH

`define SST_CLK_NS      50
`define SST_TICK_NS     1000
`define SST_TICK_CYC    (`SST_TICK_NS / `SST_CLK_NS)

// delays in microseconds of the shared timebase, channel counts and the last sequence position
`define SST_T_0P64MS_US 24'd640
`define SST_T_12P5MS_US 24'd12500
`define SST_T_25MS_US   24'd25000
`define SST_T_50MS_US   24'd50000
`define SST_T_100MS_US  24'd100000
`define SST_T_200MS_US  24'd200000
`define SST_T_400MS_US  24'd400000
`define SST_FAULT_RESTART_DELAY_US     24'd2400000
`define SST_COMMAND_RESTART_DELAY_US     24'd12500
`define SST_ADC_SLOT_US 9'd182
`define SST_ADC_CHANS   4'd11
`define SST_LOOP_SLOT_US 9'd283
`define SST_LOOP_CHANS  3'd6
`define SST_TRIM_PULSE_US 9'd5
`define SST_POS_LAST    3'd6

// register byte offsets
`define SST_REG_CTRL    8'h00
`define SST_REG_STATUS  8'h04
`define SST_REG_IRQ     8'h08
`define SST_REG_MASK    8'h0c
`define SST_REG_CH0     8'h10

// ctrl fields
`define SST_CTRL_CMD_OFF 0
`define SST_CTRL_UNLATCH 1
`define SST_CTRL_RESET_TIMEOUT_DELAY_LO 2
`define SST_CTRL_STT_LO  4
`define SST_CTRL_RETRY_LO 6

// interrupt event bits
`define SST_EV_SEQ_DONE 0
`define SST_EV_FAULT    1
`define SST_EV_STT      2
`define SST_EV_GOOD     3

`endif

// [sst_pkg.sv]
/*
 types of the supply sequence timing core.
 assumes sst_defines.svh is included by the design file.
*/
package sst_pkg;
	typedef enum logic [2:0] {SST_IDLE, SST_RESTART, SST_ON_DLY, SST_WAIT_UV, SST_RESET_TO, SST_RUN,
		SST_LATCHED} sst_state_t;

	typedef struct packed {
		logic       reg_en;
		logic       pol;
		logic [2:0] pos;
		logic [1:0] off_sel;
		logic [1:0] on_sel;
	} sst_chan_cfg_t;

	typedef struct packed {
		sst_state_t               st;
		logic [2:0]               pos;
		logic [23:0]              seq_cnt;
		logic [23:0]              stt_cnt;
		logic [5:0][15:0]         off_cnt;
		logic [5:0]               en;
		logic [5:0]               en_pin;
		logic [5:0]               mon_s1;
		logic [5:0]               mon_s2;
		logic [5:0]               abv_s1;
		logic [5:0]               abv_s2;
		logic                     req_s1;
		logic                     req_s2;
		logic                     req_d;
		logic                     fault_rst;
		logic [15:0]              tick_cnt;
		logic                     tick;
		logic [8:0]               adc_cnt;
		logic [3:0]               adc_ch;
		logic                     adc_start;
		logic [8:0]               loop_cnt;
		logic [2:0]               loop_ch;
		logic [5:0]               trim_pulse;
		logic [5:0]               trim_src;
		logic [1:0]               reset_timeout_delay_sel;
		logic [1:0]               stt_sel;
		logic [2:0]               retries;
		sst_chan_cfg_t [5:0]      cfg;
		logic [3:0]               irq_st;
		logic [3:0]               irq_mask;
		logic                     irq;
		logic                     good;
		logic                     hready;
		logic [31:0]              hrdata;
		logic                     wr_pend;
		logic [7:0]               wr_addr;
	} sst_regs_t;
endpackage

// [sst_conv_model.sv]
/*
 six dc/dc converter model: each monitor goes good a fixed delay after its enable, trim level moves per pulse.
 assumes enables active high (polarity 0) and a fail input from the bench that pulls a monitor low.
*/
`timescale 1ns/1ps
module sst_conv_model #(
	parameter int MON_DLY = 20
) (
	input  wire logic       clk_i,
	input  wire logic [5:0] enable_i,
	input  wire logic [5:0] fail_i,
	input  wire logic [5:0] pulse_i,
	input  wire logic [5:0] source_i,
	output logic      [5:0] monitor_o,
	output logic      [5:0] above_o
);
	int ramp_q [6] = '{default: 0};
	int lvl_q  [6] = '{default: 0};
	initial above_o = '0;
	// a disabled converter ramps down at once, so a stale good never lingers
	always @(posedge clk_i) begin
		for (int i = 0; i < 6; i++) begin
			ramp_q[i] <= enable_i[i] ? ((ramp_q[i] < MON_DLY) ? ramp_q[i] + 1 : MON_DLY) : 0;
			if (pulse_i[i])
				lvl_q[i] <= source_i[i] ? lvl_q[i] + 1 : lvl_q[i] - 1;
			above_o[i] <= lvl_q[i] > 0;
		end
	end
	always_comb begin
		for (int i = 0; i < 6; i++)
			monitor_o[i] = (ramp_q[i] >= MON_DLY) && !fail_i[i];
	end
endmodule // sst_conv_model

// [supply_sequence_timing_bench.sv]
/*
 self-checking bench: ahb-lite register tasks, sequencing, fault and command restarts, scan timing.
 assumes the timing core runs with a one-cycle tick and shortened restart delays.
*/
`timescale 1ns/1ps
module supply_sequence_timing_bench;
	logic        clk_sys_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        hsel      = 1'b0;
	logic [7:0]  haddr     = '0;
	logic [1:0]  htrans    = '0;
	logic        hwrite    = 1'b0;
	logic [31:0] hwdata    = '0;
	logic        req       = 1'b0;
	logic [5:0]  fail      = '0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [5:0]  mon;
	logic [5:0]  above;
	logic [5:0]  en;
	logic        good;
	logic [3:0]  adc_ch;
	logic        adc_st;
	logic [5:0]  tp;
	logic [5:0]  ts;
	logic        irq;
	logic [31:0] rd;
	logic [3:0]  ch;
	int          failures = 0;
	int          checked  = 0;
	int          cyc      = 0;
	int          n;
	int          m;

	sst_timing #(.TICK_CYC(16'd1), .FAULT_RESTART_DELAY_US(24'd200), .COMMAND_RESTART_DELAY_US(24'd50)) dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .sequence_request_in_i(req), .supply_monitor_in_i(mon),
		.trim_above_i(above), .supply_enable_out_o(en), .supply_good_o(good), .adc_channel_o(adc_ch),
		.adc_start_o(adc_st), .trim_pulse_o(tp), .trim_source_o(ts), .irq_o(irq));

	sst_conv_model conv (.clk_i(clk_sys_i), .enable_i(en), .fail_i(fail), .pulse_i(tp),
		.source_i(ts), .monitor_o(mon), .above_o(above));

	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rng(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			failures++;
			$display("mismatch at %0t: %0d cycles, expected %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// one single transfer: address phase held until hready, then data phase until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		bus(1'b0, a, 32'h0, rd);
		chk(rd & msk, exp);
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return en[0];
			1: return en[1];
			2: return mon[0];
			3: return good;
			4: return adc_st;
			5: return tp[0];
			default: return mon[1];
		endcase
	endfunction

	// bounded wait, counting edges until the chosen signal shows the value
	task automatic wt(input int s, input logic v, output int k);
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (pick(s) !== v && k < 5000);
		rng(k, 0, 4999);
	endtask

	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdc(8'h04, 32'h0, '1);
		rdc(8'h08, 32'h0, '1);
		rdc(8'h0c, 32'h0, '1);
		rdc(8'h10, 32'h0, '1);
		bus(1'b1, 8'h00, 32'h0f4, rd);
		rdc(8'h00, 32'h0f4, '1);
		bus(1'b1, 8'h00, 32'h0, rd);
		bus(1'b1, 8'h14, 32'hffff, rd);
		rdc(8'h14, 32'h1ff, '1);
		// polarity bit set: the idle enable of channel 1 shows inverted
		chk(32'(en), 32'h2);
		bus(1'b1, 8'h80, 32'hffff, rd);
		rdc(8'h80, 32'h0, '1);
		bus(1'b1, 8'h10, 32'h110, rd);
		bus(1'b1, 8'h14, 32'h020, rd);
		bus(1'b1, 8'h0c, 32'h1, rd);
		// host leaves the configuration write time before using the setup; one tick is one cycle here
		repeat (10000) @(posedge clk_sys_i);
		// request held high through the whole sequence
		req <= 1'b1;
		wt(0, 1'b1, n);
		rng(n, 640, 650);
		wt(2, 1'b1, n);
		chk(32'(en), 32'h1);
		wt(1, 1'b1, n);
		rng(n, 640, 655);
		wt(6, 1'b1, n);
		wt(3, 1'b1, n);
		rng(n, 640, 670);
		repeat (3) @(posedge clk_sys_i);
		chk(32'(irq), 32'h1);
		rdc(8'h04, 32'h1500c3, 32'h170fff);
		rdc(8'h08, 32'h9, 32'hf);
		repeat (3) @(posedge clk_sys_i);
		chk(32'(irq), 32'h0);
		wt(4, 1'b1, n);
		for (int i = 0; i < 12; i++) begin
			ch = adc_ch;
			wt(4, 1'b0, n);
			wt(4, 1'b1, m);
			rng(n + m, 182, 182);
			chk(32'(adc_ch), (ch == 4'd10) ? 32'h0 : 32'(ch + 4'd1));
		end
		wt(5, 1'b1, n);
		chk(32'(ts), {26'h0, 5'h0, ~above[0]});
		wt(5, 1'b0, n);
		rng(n, 5, 5);
		wt(5, 1'b1, m);
		chk(32'(ts), {26'h0, 5'h0, ~above[0]});
		rng(n + m, 1698, 1698);
		// zero retries: fault latches the block off
		fail <= 6'h1;
		wt(0, 1'b0, n);
		rng(n, 640, 655);
		repeat (400) @(posedge clk_sys_i);
		chk(32'(en), 32'h0);
		rdc(8'h04, 32'h60000, 32'h70000);
		rdc(8'h08, 32'h2, 32'h2);
		fail <= 6'h0;
		bus(1'b1, 8'h00, 32'h2, rd);
		bus(1'b1, 8'h00, 32'h40, rd);
		req <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		req <= 1'b1;
		wt(3, 1'b1, n);
		// retries enabled: fault restarts after the fault delay plus turn-on delay
		fail <= 6'h1;
		wt(0, 1'b0, n);
		fail <= 6'h0;
		wt(0, 1'b1, n);
		rng(n, 840, 870);
		wt(3, 1'b1, n);
		bus(1'b1, 8'h00, 32'h41, rd);
		wt(0, 1'b0, n);
		wt(0, 1'b1, n);
		rng(n, 690, 720);
		// sequence-off: dropping the request in run clears every enable after the two-stage sync
		wt(3, 1'b1, n);
		req <= 1'b0;
		wt(0, 1'b0, n);
		rng(n, 4, 4);
		chk(32'(good), 32'h0);
		chk(32'(hresp), 32'h0);
		tally_and_finish();
	end
endmodule // supply_sequence_timing_bench
